// [rtl/ssw_pkg.sv]
// shared constants and carrier types for the supply supervisor and watchdog reset block
package ssw_pkg;
  localparam int unsigned CLOCK_HZ = 250_000_000;
  localparam int unsigned RESET_TIMEOUT_MS = 200;
  localparam int unsigned WATCHDOG_TIMEOUT_MS = 1600;
  localparam int unsigned DEBOUNCE_US = 5;
  localparam longint unsigned RESET_TIMEOUT_CYC = longint'(CLOCK_HZ) / 1000 * RESET_TIMEOUT_MS;
  localparam longint unsigned WATCHDOG_CYC = longint'(CLOCK_HZ) / 1000 * WATCHDOG_TIMEOUT_MS;
  localparam longint unsigned DEBOUNCE_CYC = longint'(CLOCK_HZ) / 1000000 * DEBOUNCE_US;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned SYNC_DEPTH = 3;
  localparam logic [2:0] SYNC_RESET = 3'h7;
  // cycles after letting go of the reset wire before its sensed level is trusted
  localparam logic [31:0] PROBE_CYC = 32'h5;

  typedef enum logic [1:0] {
    SSW_ST_HOLD,
    SSW_ST_TIMEOUT,
    SSW_ST_RUN
  } ssw_state_t;

  // pin inputs after the edge of the block
  typedef struct packed {
    logic supply_good;
    logic manual_reset_request_n;
    logic reset_pin_n;
    logic watchdog_kick_in;
    logic sda_in;
    logic write_protect;
  } ssw_pins_t;

  // all registered state of the supervisor
  typedef struct packed {
    ssw_state_t state;
    logic [CNT_W-1:0] timeout_cnt;
    logic [CNT_W-1:0] wdog_cnt;
    logic [CNT_W-1:0] deb_cnt;
    logic mr_settled_n;
    logic [SYNC_DEPTH-1:0] sync_pg;
    logic [SYNC_DEPTH-1:0] sync_mr;
    logic [SYNC_DEPTH-1:0] sync_rst;
    logic [SYNC_DEPTH-1:0] sync_wdi;
    logic [SYNC_DEPTH-1:0] sync_sda;
    logic [SYNC_DEPTH-1:0] sync_wp;
    logic supply_ok;
    logic mr_level_n;
    logic rst_level_n;
    logic wdi_level;
    logic sda_level;
    logic wp_level;
    logic reset_high;
    logic reset_low_oe;
    logic write_enable;
    logic kick_seen;
  } ssw_regs_t;
endpackage

// [rtl/ssw_supervisor.sv]
// supervisor core: supply, manual and forced reset, watchdog, write gating
//
// Function
// - While the supply is below threshold the active-high reset is high and active-low reset low.
// - After the supply comes good both resets stay asserted for the 200 ms timeout.
// - A low manual reset asserts reset while low and for a full timeout after it rises.
// - The manual reset input counts only once it has settled low for the debounce time.
// - A floating manual reset input reads high and is inactive.
// - Forcing the active-low reset pin low from outside holds reset for as long as it is forced.
// - With the dedicated kick input either edge restarts the watchdog; 1.6 s without one resets.
// - Without that input, activity on the serial data line services the watchdog.
// - A high write-protect input blocks all array writes; low or floating allows them.
// - Writes are blocked while the supply is below threshold, including before first good.
`timescale 1ns/100ps
module ssw_supervisor #(
  parameter logic [31:0] RESET_TIMEOUT = 32'(ssw_pkg::RESET_TIMEOUT_CYC),
  parameter logic [31:0] WATCHDOG_TIMEOUT = 32'(ssw_pkg::WATCHDOG_CYC),
  parameter logic [31:0] DEBOUNCE = 32'(ssw_pkg::DEBOUNCE_CYC),
  parameter bit HAS_KICK_PIN = 1'b1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire ssw_pkg::ssw_pins_t pins,
  output logic reset_active_high,
  output logic reset_low_out,
  output logic reset_low_oe,
  output logic write_enable
);
  ssw_pkg::ssw_regs_t r;
  ssw_pkg::ssw_regs_t next_r;
  logic cause;
  logic kick;
  logic [ssw_pkg::SYNC_DEPTH-1:0] pin_now;

  // a change counts only once stages two and three agree
  function automatic logic settle(input logic [2:0] s, input logic held);
    settle = (s[1] == s[2]) ? s[2] : held;
  endfunction

  function automatic logic [31:0] bump(input logic [31:0] c);
    bump = (c == 32'hffffffff) ? c : c + 32'h1;
  endfunction

  always_comb begin
    next_r = r;
    cause = 1'b0;
    kick = 1'b0;
    pin_now = '0;
    next_r.sync_pg = {r.sync_pg[1:0], pins.supply_good};
    next_r.sync_mr = {r.sync_mr[1:0], pins.manual_reset_request_n};
    // own open-drain drive must not read back as an outside force
    next_r.sync_rst = {r.sync_rst[1:0], pins.reset_pin_n | r.reset_low_oe};
    next_r.sync_wdi = {r.sync_wdi[1:0], pins.watchdog_kick_in};
    next_r.sync_sda = {r.sync_sda[1:0], pins.sda_in};
    next_r.sync_wp = {r.sync_wp[1:0], pins.write_protect};
    next_r.supply_ok = settle(r.sync_pg, r.supply_ok);
    next_r.mr_level_n = settle(r.sync_mr, r.mr_level_n);
    next_r.rst_level_n = settle(r.sync_rst, r.rst_level_n);
    next_r.wdi_level = settle(r.sync_wdi, r.wdi_level);
    next_r.sda_level = settle(r.sync_sda, r.sda_level);
    next_r.wp_level = settle(r.sync_wp, r.wp_level);
    pin_now[0] = r.mr_level_n;

    if (r.mr_level_n) begin
      next_r.deb_cnt = '0;
      next_r.mr_settled_n = 1'b1;
    end else if (r.deb_cnt >= DEBOUNCE - 32'h1) begin
      next_r.mr_settled_n = 1'b0;
    end else begin
      next_r.deb_cnt = bump(r.deb_cnt);
    end

    // either edge of the kick input
    if (HAS_KICK_PIN) begin
      kick = r.wdi_level != next_r.wdi_level;
    end else begin
      // serial data activity services the watchdog
      kick = r.sda_level != next_r.sda_level;
    end
    next_r.kick_seen = kick;

    cause = !r.supply_ok || !r.mr_settled_n || !r.rst_level_n;

    case (r.state)
      ssw_pkg::SSW_ST_HOLD: begin
        next_r.timeout_cnt = '0;
        next_r.wdog_cnt = '0;
        if (!cause) begin
          next_r.state = ssw_pkg::SSW_ST_TIMEOUT;
        end
      end
      ssw_pkg::SSW_ST_TIMEOUT: begin
        next_r.wdog_cnt = '0;
        if (cause) begin
          next_r.state = ssw_pkg::SSW_ST_HOLD;
          next_r.timeout_cnt = '0;
        end else if (r.timeout_cnt >= RESET_TIMEOUT - 32'h1) begin
          next_r.state = ssw_pkg::SSW_ST_RUN;
          next_r.timeout_cnt = '0;
        end else begin
          next_r.timeout_cnt = bump(r.timeout_cnt);
        end
      end
      ssw_pkg::SSW_ST_RUN: begin
        // own drive masks the wire, so probe it before releasing the high output
        if (r.timeout_cnt < ssw_pkg::PROBE_CYC) begin
          next_r.timeout_cnt = bump(r.timeout_cnt);
        end
        if (cause) begin
          next_r.state = ssw_pkg::SSW_ST_HOLD;
          next_r.wdog_cnt = '0;
        end else if (kick) begin
          next_r.wdog_cnt = '0;
        end else if (r.wdog_cnt >= WATCHDOG_TIMEOUT - 32'h1) begin
          // watchdog expiry starts a timed reset
          next_r.state = ssw_pkg::SSW_ST_TIMEOUT;
          next_r.wdog_cnt = '0;
          next_r.timeout_cnt = '0;
        end else begin
          next_r.wdog_cnt = bump(r.wdog_cnt);
        end
      end
      default: begin
        next_r.state = ssw_pkg::SSW_ST_HOLD;
      end
    endcase

    next_r.reset_high = (next_r.state != ssw_pkg::SSW_ST_RUN) ||
      (next_r.timeout_cnt < ssw_pkg::PROBE_CYC);
    next_r.reset_low_oe = next_r.state != ssw_pkg::SSW_ST_RUN;
    // write gating by protect pin and supply
    next_r.write_enable = next_r.supply_ok && !next_r.wp_level;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      r <= '0;
      r.state <= ssw_pkg::SSW_ST_HOLD;
      r.sync_mr <= ssw_pkg::SYNC_RESET;
      r.mr_level_n <= 1'b1;
      r.mr_settled_n <= 1'b1;
      r.sync_rst <= ssw_pkg::SYNC_RESET;
      r.rst_level_n <= 1'b1;
      r.reset_high <= 1'b1;
      r.reset_low_oe <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign reset_active_high = r.reset_high;
  assign reset_low_out = 1'b0;
  assign reset_low_oe = r.reset_low_oe;
  assign write_enable = r.write_enable;

  // checks
  logic past_ok;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      past_ok <= 1'b0;
    end else begin
      past_ok <= 1'b1;
    end
  end

  a_supply_low_reset: assert property (@(posedge clock) disable iff (!rst_n)
    !r.supply_ok |=> reset_active_high && reset_low_oe)
    else $error("reset not asserted with supply low");
  a_outputs_agree: assert property (@(posedge clock) disable iff (!rst_n)
    reset_low_oe |-> reset_active_high)
    else $error("reset outputs disagree");
  a_timeout_counts: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(r.state == ssw_pkg::SSW_ST_RUN) |-> $past(r.timeout_cnt) == RESET_TIMEOUT - 32'h1)
    else $error("release before full timeout");
  a_manual_holds: assert property (@(posedge clock) disable iff (!rst_n)
    !r.mr_settled_n |=> reset_active_high)
    else $error("manual reset not held");
  a_debounce_len: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(r.mr_settled_n) |-> $past(r.deb_cnt) == DEBOUNCE - 32'h1)
    else $error("manual reset taken before settled");
  a_forced_pin: assert property (@(posedge clock) disable iff (!rst_n)
    past_ok && !r.rst_level_n |=> r.state == ssw_pkg::SSW_ST_HOLD)
    else $error("forced reset pin not held");
  a_wdog_clear: assert property (@(posedge clock) disable iff (!rst_n)
    r.state != ssw_pkg::SSW_ST_RUN |-> r.wdog_cnt == '0)
    else $error("watchdog counting during reset");
  a_kick_restart: assert property (@(posedge clock) disable iff (!rst_n)
    r.kick_seen && r.state == ssw_pkg::SSW_ST_RUN && $past(r.state) == ssw_pkg::SSW_ST_RUN
    |-> r.wdog_cnt == '0)
    else $error("kick did not restart watchdog");
  a_write_gate: assert property (@(posedge clock) disable iff (!rst_n)
    (r.wp_level || !r.supply_ok) |-> !write_enable)
    else $error("write allowed while protected");
  a_cause_restart: assert property (@(posedge clock) disable iff (!rst_n)
    r.state == ssw_pkg::SSW_ST_TIMEOUT && !r.supply_ok |=> r.state == ssw_pkg::SSW_ST_HOLD)
    else $error("timeout not restarted by cause");

  c_release: cover property (@(posedge clock) disable iff (!rst_n)
    $rose(r.state == ssw_pkg::SSW_ST_RUN));
  c_watchdog_fire: cover property (@(posedge clock) disable iff (!rst_n)
    $past(r.state) == ssw_pkg::SSW_ST_RUN && r.state == ssw_pkg::SSW_ST_TIMEOUT);
  c_manual: cover property (@(posedge clock) disable iff (!rst_n) $fell(r.mr_settled_n));
  c_forced: cover property (@(posedge clock) disable iff (!rst_n) $fell(r.rst_level_n));
endmodule

// [bench/ssw_mcu_model.sv]
// system controller model: services the watchdog and may force the reset wire
`timescale 1ns/100ps
module ssw_mcu_model (
  input wire logic clock,
  input wire logic kick_en,
  input wire logic [7:0] kick_gap,
  input wire logic force_low,
  output logic kick,
  output logic pull_low
);
  logic [7:0] cnt = 8'h00;
  initial kick = 1'b0;
  // toggle kick pin
  // either edge counts, so a plain toggle halves the pin rate
  always @(negedge clock) begin
    cnt <= (cnt >= kick_gap) ? 8'h00 : cnt + 8'h01;
    if (kick_en && cnt >= kick_gap) kick <= ~kick;
  end
  assign pull_low = force_low;
endmodule

// [bench/tb_top.sv]
// self-checking bench for the supervisor block
`timescale 1ns/100ps
module tb_top;
  localparam int RT = 20;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic pg, mr_n, wp, sda, kick_en, force_low, kick, pull_low;
  logic rah, rlo, oe, we;
  logic [7:0] gap;
  ssw_pkg::ssw_pins_t pins;
  int error_cnt = 0;
  int comparisons = 0;
  int n;
  initial forever #2 clock = ~clock;
  // pulled-up reset wire: low while either party pulls
  assign pins = '{supply_good: pg, manual_reset_request_n: mr_n,
    reset_pin_n: ~(oe | pull_low), watchdog_kick_in: kick, sda_in: sda, write_protect: wp};
  ssw_supervisor #(.RESET_TIMEOUT(32'h14), .WATCHDOG_TIMEOUT(32'h32), .DEBOUNCE(32'h4),
    .HAS_KICK_PIN(1'b1)) u_dut (.clock(clock), .rst_n(rst_n), .pins(pins),
    .reset_active_high(rah), .reset_low_out(rlo), .reset_low_oe(oe), .write_enable(we));
  ssw_mcu_model u_mcu (.clock(clock), .kick_en(kick_en), .kick_gap(gap),
    .force_low(force_low), .kick(kick), .pull_low(pull_low));
  function automatic logic exp_we(input logic good, input logic prot);
    return good & ~prot;
  endfunction
  task automatic results();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic check_rst(input logic e);
    comparisons++;
    // the active-low wire is judged by its level, whoever pulls it
    if (rah !== e || (oe | pull_low) !== e || rlo !== 1'b0) begin
      error_cnt++;
      $display("[FAIL] %0t reset exp %h got %h %h %h", $time, e, rah, oe, rlo);
    end
  endtask
  task automatic check_we(input logic e);
    comparisons++;
    if (we !== e) begin
      error_cnt++;
      $display("[FAIL] %0t write enable exp %h got %h", $time, e, we);
    end
  endtask
  // bounded wait for the reset level; a hang ends the run
  task automatic wait_rst(input logic e, input int lim);
    n = 0;
    while (rah !== e && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) begin
      error_cnt++;
      $display("[FAIL] %0t wait exp %h got %h", $time, e, rah);
      results();
    end
  endtask
  initial begin
    pg = 1'b0;
    mr_n = 1'b1;
    wp = 1'b0;
    sda = 1'b1;
    kick_en = 1'b1;
    force_low = 1'b0;
    gap = 8'h0a;
    void'($urandom(32'h41a7fd73));
    cyc(3);
    rst_n = 1'b1;
    cyc(6);
    check_rst(1'b1);
    check_we(exp_we(pg, wp));
    pg = 1'b1;
    cyc(5 + RT / 2);
    check_rst(1'b1);
    wait_rst(1'b0, RT + 10);
    cyc(1);
    check_rst(1'b0);
    for (int i = 0; i < 8; i++) begin
      wp = 1'($urandom_range(1, 0));
      cyc(6);
      check_we(exp_we(pg, wp));
    end
    wp = 1'b0;
    // short glitch below the settle time
    mr_n = 1'b0;
    cyc(2);
    mr_n = 1'b1;
    cyc(8);
    check_rst(1'b0);
    mr_n = 1'b0;
    cyc(12);
    check_rst(1'b1);
    mr_n = 1'b1;
    cyc(5 + RT / 2);
    check_rst(1'b1);
    wait_rst(1'b0, RT + 10);
    force_low = 1'b1;
    cyc(10 + $urandom_range(20, 0));
    check_rst(1'b1);
    force_low = 1'b0;
    cyc(1);
    check_rst(1'b1);
    wait_rst(1'b0, RT + 10);
    gap = 8'($urandom_range(40, 10));
    cyc(150);
    check_rst(1'b0);
    // kicks stop: expiry must come within the watchdog span plus latency
    kick_en = 1'b0;
    wait_rst(1'b1, 50 + 10);
    kick_en = 1'b1;
    wait_rst(1'b0, RT + 10);
    pg = 1'b0;
    cyc(6);
    check_rst(1'b1);
    check_we(exp_we(pg, wp));
    results();
  end
endmodule
